//--- design/flash_query_burst_partition_table.sv
// Read-only query table for burst capability and partition region 1 geometry
`timescale 1ns/100ps
`default_nettype none
`include "flash_query_regs.svh"
module flash_query_burst_partition_table #(
	parameter logic [7:0] PART_REGION_COUNT = `VAL_PART_REGION_COUNT,
	parameter logic [15:0] INFO_SIZE = `VAL_INFO_SIZE,
	parameter logic [15:0] IDENT_PART = `VAL_IDENT_PART,
	parameter logic [7:0] LOCAL_CONC = `VAL_LOCAL_CONC,
	parameter logic [7:0] CONC_PROGRAM = `VAL_CONC_PROGRAM,
	parameter logic [7:0] CONC_ERASE = `VAL_CONC_ERASE,
	parameter logic [7:0] ERASE_REGION_COUNT = `VAL_ERASE_REGION_COUNT
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic [15:0] queryData,
	output logic regionFieldsPresent
);
	// ****************************************
	// Decode
	// ****************************************
	flash_query_pkg::qryIndex_t index;
	flash_query_pkg::qryByte_t lookup;
	logic hit;
	logic request;
	flash_query_pkg::busState_e state_q;
	logic [31:0] writeSink;

	assign index = wb_adr_i[13:2];
	assign request = wb_cyc_i && wb_stb_i && (state_q == flash_query_pkg::BUS_IDLE);
	// Write data and lanes have nowhere to go in a read-only table
	assign writeSink = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
		{8{wb_sel_i[0]}}};

	// Table lookup; unmapped indices return zero and raise err
	always_comb begin
		hit = 1'b1;
		unique case (index)
			`QRY_SYNC_FIELD_COUNT: lookup = `VAL_SYNC_FIELD_COUNT;
			`QRY_BURST_CAP_ONE: lookup = `VAL_BURST_CAP_ONE;
			`QRY_BURST_CAP_TWO: lookup = `VAL_BURST_CAP_TWO;
			`QRY_BURST_CAP_THREE: lookup = `VAL_BURST_CAP_THREE;
			`QRY_BURST_CAP_FOUR: lookup = `VAL_BURST_CAP_FOUR;
			`QRY_PART_REGION_COUNT: lookup = PART_REGION_COUNT;
			`QRY_INFO_SIZE_LO: lookup = INFO_SIZE[7:0];
			`QRY_INFO_SIZE_HI: lookup = INFO_SIZE[15:8];
			`QRY_IDENT_PART_LO: lookup = IDENT_PART[7:0];
			`QRY_IDENT_PART_HI: lookup = IDENT_PART[15:8];
			`QRY_LOCAL_CONC: lookup = LOCAL_CONC;
			`QRY_CONC_PROGRAM: lookup = CONC_PROGRAM;
			`QRY_CONC_ERASE: lookup = CONC_ERASE;
			`QRY_ERASE_REGION_COUNT: lookup = ERASE_REGION_COUNT;
			default: begin
				lookup = 8'h00;
				hit = 1'b0;
			end
		endcase
		// Region fields vanish when the device reports a single partition
		if (PART_REGION_COUNT == 8'h00 && index >= `QRY_INFO_SIZE_LO &&
			index <= `QRY_ERASE_REGION_COUNT) begin
			lookup = 8'h00;
			hit = 1'b0;
		end
	end

	// ****************************************
	// Bus handshake
	// ****************************************
	// One-cycle ack or err a cycle after the request, then one idle cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q <= flash_query_pkg::BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= request && hit;
			wb_err_o <= request && !hit;
			state_q <= request ? flash_query_pkg::BUS_ACKED : flash_query_pkg::BUS_IDLE;
		end
	end

	// Read data; writes get ack or err like reads but store nothing
	always_ff @(posedge mclk) begin
		if (reset) begin
			wb_dat_o <= 32'h00000000;
			queryData <= 16'h0000;
		end else if (request) begin
			wb_dat_o <= {24'h000000, lookup};
			if (!wb_we_i) begin
				queryData <= {8'h00, lookup};
			end
		end
	end

	// Region presence flag
	always_ff @(posedge mclk) begin
		if (reset) begin
			regionFieldsPresent <= 1'b0;
		end else begin
			regionFieldsPresent <= (PART_REGION_COUNT != 8'h00);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_req(logic [11:0] idx);
		wb_cyc_i && wb_stb_i && !wb_we_i && state_q == flash_query_pkg::BUS_IDLE && index == idx;
	endsequence

	property p_cap_one;
		@(posedge mclk) disable iff (reset) s_req(`QRY_BURST_CAP_ONE) |=> wb_ack_o &&
			wb_dat_o == 32'h00000001;
	endproperty
	a_cap_one: assert property (p_cap_one) else $error("burst cap one wrong");

	property p_cont;
		@(posedge mclk) disable iff (reset) s_req(`QRY_BURST_CAP_FOUR) |=>
			wb_dat_o[`BURST_CODE_MSB:`BURST_CODE_LSB] == `VAL_BURST_CONTINUOUS;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous code wrong");

	property p_cap_two;
		@(posedge mclk) disable iff (reset) s_req(`QRY_BURST_CAP_TWO) |=> wb_dat_o == 32'h00000002;
	endproperty
	a_cap_two: assert property (p_cap_two) else $error("burst cap two wrong");

	property p_cap_three;
		@(posedge mclk) disable iff (reset) s_req(`QRY_BURST_CAP_THREE) |=> wb_dat_o == 32'h00000003;
	endproperty
	a_cap_three: assert property (p_cap_three) else $error("burst cap three wrong");

	property p_cap_four;
		@(posedge mclk) disable iff (reset) s_req(`QRY_BURST_CAP_FOUR) |=> wb_dat_o == 32'h00000007;
	endproperty
	a_cap_four: assert property (p_cap_four) else $error("burst cap four wrong");

	property p_count;
		@(posedge mclk) disable iff (reset) s_req(`QRY_SYNC_FIELD_COUNT) |=> wb_dat_o == 32'h00000004;
	endproperty
	a_count: assert property (p_count) else $error("config count wrong");

	property p_region;
		@(posedge mclk) disable iff (reset) s_req(`QRY_PART_REGION_COUNT) |=>
			wb_dat_o[7:0] == PART_REGION_COUNT && regionFieldsPresent == (PART_REGION_COUNT != 8'h00);
	endproperty
	a_region: assert property (p_region) else $error("region count wrong");

	property p_size;
		@(posedge mclk) disable iff (reset) s_req(`QRY_INFO_SIZE_HI) |=>
			wb_dat_o[7:0] == INFO_SIZE[15:8] || PART_REGION_COUNT == 8'h00;
	endproperty
	a_size: assert property (p_size) else $error("info size high byte wrong");

	property p_ident;
		@(posedge mclk) disable iff (reset) s_req(`QRY_IDENT_PART_LO) |=>
			wb_dat_o[7:0] == IDENT_PART[7:0] || PART_REGION_COUNT == 8'h00;
	endproperty
	a_ident: assert property (p_ident) else $error("partition count wrong");

	property p_upper_zero;
		@(posedge mclk) disable iff (reset) wb_ack_o |-> wb_dat_o[31:8] == 24'h000000 &&
			queryData[15:8] == 8'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper lanes not zero");

	property p_write_inert;
		@(posedge mclk) disable iff (reset) wb_cyc_i && wb_stb_i && wb_we_i &&
			state_q == flash_query_pkg::BUS_IDLE && index == `QRY_LOCAL_CONC |=>
			wb_dat_o[7:0] == ((PART_REGION_COUNT == 8'h00) ? 8'h00 : LOCAL_CONC) &&
			$stable(queryData);
	endproperty
	a_write_inert: assert property (p_write_inert) else $error("write altered table");

	property p_ack_pulse;
		@(posedge mclk) disable iff (reset) wb_ack_o |=> !wb_ack_o && !wb_err_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");

	property p_erase_nibbles;
		@(posedge mclk) disable iff (reset) s_req(`QRY_CONC_ERASE) ##1 wb_ack_o |->
			wb_dat_o[7:`NIBBLE_ERASE_LSB] == CONC_ERASE[7:4] &&
			wb_dat_o[3:`NIBBLE_PROGRAM_LSB] == CONC_ERASE[3:0];
	endproperty
	a_erase_nibbles: assert property (p_erase_nibbles) else $error("erase nibbles wrong");

	property p_prog_conc;
		@(posedge mclk) disable iff (reset) s_req(`QRY_CONC_PROGRAM) ##1 wb_ack_o |->
			wb_dat_o[7:0] == CONC_PROGRAM;
	endproperty
	a_prog_conc: assert property (p_prog_conc) else $error("program concurrency wrong");

	property p_erase_regions;
		@(posedge mclk) disable iff (reset) s_req(`QRY_ERASE_REGION_COUNT) ##1 wb_ack_o |->
			wb_dat_o[7:0] == ERASE_REGION_COUNT;
	endproperty
	a_erase_regions: assert property (p_erase_regions) else $error("erase region count wrong");

	property p_sink;
		@(posedge mclk) disable iff (reset) wb_we_i && wb_ack_o |-> $stable(queryData);
	endproperty
	a_sink: assert property (p_sink) else $error("write reached query data");

	// ****************************************
	// Handshake and decode assertions
	// ****************************************
	// Any request taken while idle, read or write alike
	sequence s_take;
		wb_cyc_i && wb_stb_i && state_q == flash_query_pkg::BUS_IDLE;
	endsequence

	// An answer of one cycle, then a quiet cycle
	sequence s_answer_then_quiet;
		(wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
	endsequence

	property p_answer;
		@(posedge mclk) disable iff (reset) s_take |=> s_answer_then_quiet;
	endproperty
	a_answer: assert property (p_answer) else $error("answer not one cycle");

	property p_err_pulse;
		@(posedge mclk) disable iff (reset) wb_err_o |=> !wb_err_o && !wb_ack_o;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("err longer than a cycle");

	// Indices outside the table answer with err and zero data
	property p_unmapped;
		@(posedge mclk) disable iff (reset) s_take ##0
			(index < `QRY_SYNC_FIELD_COUNT || index > `QRY_ERASE_REGION_COUNT) |=>
			wb_err_o && !wb_ack_o && wb_dat_o == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped index answered");

	// A single-partition table hides every region field
	property p_region_absent;
		@(posedge mclk) disable iff (reset) s_take ##0 (PART_REGION_COUNT == 8'h00 &&
			index >= `QRY_INFO_SIZE_LO && index <= `QRY_ERASE_REGION_COUNT) |=>
			wb_err_o && wb_dat_o == 32'h00000000;
	endproperty
	a_region_absent: assert property (p_region_absent) else $error("hidden field");

	// Reserved bits of the burst capability bytes read zero
	property p_cap_reserved;
		@(posedge mclk) disable iff (reset) s_take ##0 (!wb_we_i &&
			index >= `QRY_BURST_CAP_ONE && index <= `QRY_BURST_CAP_FOUR) |=>
			wb_dat_o[7:`BURST_CODE_MSB + 1] == 5'h00;
	endproperty
	a_cap_reserved: assert property (p_cap_reserved) else $error("reserved bits set");

	property p_size_lo;
		@(posedge mclk) disable iff (reset) s_req(`QRY_INFO_SIZE_LO) |=>
			wb_dat_o[7:0] == ((PART_REGION_COUNT == 8'h00) ? 8'h00 : INFO_SIZE[7:0]);
	endproperty
	a_size_lo: assert property (p_size_lo) else $error("info size low byte wrong");

	property p_ident_hi;
		@(posedge mclk) disable iff (reset) s_req(`QRY_IDENT_PART_HI) |=>
			wb_dat_o[7:0] == ((PART_REGION_COUNT == 8'h00) ? 8'h00 : IDENT_PART[15:8]);
	endproperty
	a_ident_hi: assert property (p_ident_hi) else $error("partition count high wrong");

	property p_local_conc;
		@(posedge mclk) disable iff (reset) s_req(`QRY_LOCAL_CONC) |=>
			wb_dat_o[7:0] == ((PART_REGION_COUNT == 8'h00) ? 8'h00 : LOCAL_CONC);
	endproperty
	a_local_conc: assert property (p_local_conc) else $error("local concurrency wrong");

	// A write carrying payload still answers with the table byte
	property p_write_payload;
		@(posedge mclk) disable iff (reset) s_take ##0 (wb_we_i &&
			index == `QRY_BURST_CAP_ONE && writeSink != 32'h00000000) |=>
			wb_dat_o == {24'h000000, `VAL_BURST_CAP_ONE} && $stable(queryData);
	endproperty
	a_write_payload: assert property (p_write_payload) else $error("write payload kept");

	// Only a taken read moves the query data output
	property p_query_hold;
		@(posedge mclk) disable iff (reset) !(wb_cyc_i && wb_stb_i && !wb_we_i &&
			state_q == flash_query_pkg::BUS_IDLE) |=> $stable(queryData);
	endproperty
	a_query_hold: assert property (p_query_hold) else $error("query data moved");

	// Reset clears every answer and the data outputs
	property p_reset_quiet;
		@(posedge mclk) reset |=> !wb_ack_o && !wb_err_o && wb_dat_o == 32'h00000000 &&
			queryData == 16'h0000 && !regionFieldsPresent;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live in reset");

	// The presence flag follows the configured region count
	property p_present;
		@(posedge mclk) disable iff (reset) !reset |=>
			regionFieldsPresent == (PART_REGION_COUNT != 8'h00);
	endproperty
	a_present: assert property (p_present) else $error("presence flag wrong");
endmodule : flash_query_burst_partition_table
`default_nettype wire

//--- pkg/flash_query_pkg.sv
// Types shared by the query table
package flash_query_pkg;
	typedef logic [11:0] qryIndex_t;
	typedef logic [7:0] qryByte_t;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACKED = 1'b1
	} busState_e;
endpackage : flash_query_pkg

//--- pkg/flash_query_regs.svh
// Query table offsets, widths and contents for the burst and partition fields
`ifndef FLASH_QUERY_REGS_SVH
`define FLASH_QUERY_REGS_SVH
// ****************************************
// Query locations as word indices; the bus byte address is 4 x index
// ****************************************
`define QRY_SYNC_FIELD_COUNT 12'h128
`define QRY_BURST_CAP_ONE 12'h129
`define QRY_BURST_CAP_TWO 12'h12a
`define QRY_BURST_CAP_THREE 12'h12b
`define QRY_BURST_CAP_FOUR 12'h12c
`define QRY_PART_REGION_COUNT 12'h12d
`define QRY_INFO_SIZE_LO 12'h12e
`define QRY_INFO_SIZE_HI 12'h12f
`define QRY_IDENT_PART_LO 12'h130
`define QRY_IDENT_PART_HI 12'h131
`define QRY_LOCAL_CONC 12'h132
`define QRY_CONC_PROGRAM 12'h133
`define QRY_CONC_ERASE 12'h134
`define QRY_ERASE_REGION_COUNT 12'h135
// ****************************************
// Field layout
// ****************************************
`define BURST_CODE_LSB 0
`define BURST_CODE_MSB 2
`define NIBBLE_PROGRAM_LSB 0
`define NIBBLE_ERASE_LSB 4
// ****************************************
// Contents
// ****************************************
`define VAL_SYNC_FIELD_COUNT 8'h04
`define VAL_BURST_CAP_ONE 8'h01
`define VAL_BURST_CAP_TWO 8'h02
`define VAL_BURST_CAP_THREE 8'h03
`define VAL_BURST_CAP_FOUR 8'h07
`define VAL_BURST_CONTINUOUS 3'h7
`define VAL_PART_REGION_COUNT 8'h01
`define VAL_INFO_SIZE 16'h0024
`define VAL_IDENT_PART 16'h0001
`define VAL_LOCAL_CONC 8'h11
`define VAL_CONC_PROGRAM 8'h00
`define VAL_CONC_ERASE 8'h11
`define VAL_ERASE_REGION_COUNT 8'h01
`endif

//--- verification/flash_query_burst_partition_table_test.sv
// Self-checking bench for the burst and partition query table
`timescale 1ns/100ps
`default_nettype none
`include "flash_query_regs.svh"
module flash_query_burst_partition_table_test;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic cyc, stb, we, ack, err, present;
	logic [15:0] adr, queryData;
	logic [3:0] sel;
	logic [31:0] datW, datR;
	logic [2:0] burstField;
	logic ack0, err0, present0;
	logic lastErr0 = 1'b0;
	logic [15:0] queryData0;
	logic [31:0] datR0;
	logic [31:0] lastDat0 = 32'h0;
	int nErrors = 0;
	int comparisons = 0;
	// Expected bytes for indices 128h..135h
	localparam logic [7:0] EXP [14] = '{
		`VAL_SYNC_FIELD_COUNT,
		8'h01, 8'h02, 8'h03, 8'h07,
		`VAL_PART_REGION_COUNT,
		8'(`VAL_INFO_SIZE), 8'(`VAL_INFO_SIZE >> 8),
		8'(`VAL_IDENT_PART), 8'(`VAL_IDENT_PART >> 8),
		`VAL_LOCAL_CONC, `VAL_CONC_PROGRAM, `VAL_CONC_ERASE,
		`VAL_ERASE_REGION_COUNT};
	// ****************************************
	// Clock, design and host
	// ****************************************
	always #2.5 mclk = ~mclk;
	flash_query_burst_partition_table dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
		.wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err), .queryData(queryData),
		.regionFieldsPresent(present));
	host_query_reader host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(datW), .ack(ack), .err(err), .datIn(datR), .burstField(burstField));
	// Single-partition variant on the same bus, watched but never waited on
	flash_query_burst_partition_table #(.PART_REGION_COUNT(8'h00)) dutSingle (.mclk(mclk),
		.reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR0), .wb_ack_o(ack0), .wb_err_o(err0),
		.queryData(queryData0), .regionFieldsPresent(present0));
	// Latch the variant's last answer while it stands
	always @(posedge mclk) begin
		if (ack0 || err0) begin
			lastErr0 <= err0;
			lastDat0 <= datR0;
		end
	end
	// ****************************************
	// Compare, verdict and bus helper
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nErrors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic printVerdict();
		if (nErrors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : printVerdict
	// One access with its ack and err outcome judged
	task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd,
		input logic expAck, output logic [31:0] rd);
		logic a, e, h;
		host.access(w, {2'b00, idx, 2'b00}, wd, rd, a, e, h);
		if (h) begin
			nErrors++;
			printVerdict();
		end else begin
			check("ack", {31'h0, a}, {31'h0, expAck});
			check("err", {31'h0, e}, {31'h0, !expAck});
		end
	endtask : xfer
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic readWholeTable();
		logic [31:0] rd, capOne, capFour;
		capOne = 32'h0;
		capFour = 32'h0;
		for (int i = 0; i < 14; i++) begin
			xfer(1'b0, 12'h128 + 12'(i), 32'h0, 1'b1, rd);
			check("table byte", rd, {24'h0, EXP[i]});
			check("queryData", {16'h0, queryData}, {24'h0, EXP[i]});
			if (i == 1) capOne = rd;
			if (i == 4) capFour = rd;
			check("single err", {31'h0, lastErr0}, {31'h0, i > 5});
			check("single byte", lastDat0, (i < 5) ? {24'h0, EXP[i]} : 32'h0);
			check("single data", {16'h0, queryData0}, (i < 5) ? {24'h0, EXP[i]} : 32'h0);
		end
		check("burst field", {29'h0, burstField}, 32'h1);
		check("four words", 32'h1 << (capOne[2:0] + 3'h1), 32'h4);
		check("continuous", {29'h0, capFour[2:0]}, {29'h0, `VAL_BURST_CONTINUOUS});
		check("regions present", {31'h0, present}, 32'h1);
		check("single regions", {31'h0, present0}, 32'h0);
	endtask : readWholeTable
	task automatic writesIgnored();
		logic [31:0] rd;
		xfer(1'b0, 12'h128, 32'h0, 1'b1, rd);
		check("count byte", rd, {24'h0, `VAL_SYNC_FIELD_COUNT});
		xfer(1'b1, 12'h129, 32'hffff_ffff, 1'b1, rd);
		check("queryData after write", {16'h0, queryData}, {24'h0, `VAL_SYNC_FIELD_COUNT});
		xfer(1'b1, 12'h132, 32'h0000_00aa, 1'b1, rd);
		xfer(1'b0, 12'h129, 32'h0, 1'b1, rd);
		check("after write 129h", rd, 32'h0000_0001);
		xfer(1'b0, 12'h132, 32'h0, 1'b1, rd);
		check("after write 132h", rd, {24'h0, `VAL_LOCAL_CONC});
	endtask : writesIgnored
	task automatic unmappedRefused();
		logic [31:0] rd;
		xfer(1'b0, 12'h127, 32'h0, 1'b0, rd);
		check("below table", rd, 32'h0);
		xfer(1'b0, 12'h136, 32'h0, 1'b0, rd);
		check("above table", rd, 32'h0);
		check("queryData after refused read", {16'h0, queryData}, 32'h0);
	endtask : unmappedRefused
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		check("data after reset", {16'h0, queryData}, 32'h0);
		readWholeTable();
		writesIgnored();
		unmappedRefused();
		printVerdict();
	end
endmodule : flash_query_burst_partition_table_test
`default_nettype wire

//--- verification/host_query_reader.sv
// Host controller model that reads the query table over classic Wishbone
`timescale 1ns/100ps
`default_nettype none
module host_query_reader (
	input wire logic mclk,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [15:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic ack,
	input wire logic err,
	input wire logic [31:0] datIn,
	output logic [2:0] burstField
);
	// ****************************************
	// Idle bus and one bus cycle
	// ****************************************
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 16'h0000;
		sel = 4'hf;
		dat = 32'h0000_0000;
		burstField = 3'h0;
	end
	// Request held until ack or err is sampled or 20 edges pass, then released with scrambled lines
	task automatic access(input logic w, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic gotAck, output logic gotErr, output logic hung);
		int i;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= wd;
		hung = 1'b1;
		gotAck = 1'b0;
		gotErr = 1'b0;
		rd = 32'h0000_0000;
		for (i = 0; i < 20 && hung; i++) begin
			@(posedge mclk);
			if (ack || err) begin
				gotAck = ack;
				gotErr = err;
				rd = datIn;
				hung = 1'b0;
			end
		end
		// Burst code copied unchanged into the read configuration field
		if (!w && gotAck && a == 16'h04a4) burstField <= rd[2:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		adr <= ~a;
		dat <= ~wd;
		@(posedge mclk);
	endtask : access
endmodule : host_query_reader
`default_nettype wire
